// ---- design/asc_config_port.sv ----
// serial configuration port and register bank of the converter
// assumes: shift_clk is the controller's clock, idle outside frames;
// over_pos/over_neg come from the sample datapath on clk
`timescale 1ns/100ps

// Operation
// RULE1 - bits are taken only while select is low; idle otherwise
// RULE2 - data is sampled on each falling shift-clock edge while selected
// RULE3 - the sixteenth falling edge commits the word to its register
// RULE4 - a trailing partial word is dropped when select rises
// RULE5 - several words in one select period each commit separately
// RULE6 - word is address a7..a0 then data d7..d0, msb first
// RULE7 - controller keeps shift clock at or below 20 mhz
// RULE8 - shared pin shows overrange after any reset until readout mode
// RULE9 - readback bit set enters readout mode; only address 0 writable
// RULE10 - in readout mode the named register shifts out d7 first
// RULE11 - controller captures readback bits on falling shift-clock edges
// RULE12 - register 0 reads back as zero in readout mode
// RULE13 - clearing readback bit leaves readout mode and restores pin
// RULE14 - high reset pulse above 10 ns returns all registers to default
// RULE15 - software reset bit in register 0 clears all, then self-clears
// RULE16 - register 1 bits 7:2 hold the six-bit amplitude code
// RULE17 - amplitude code applies only when its enable field is set
// RULE18 - performance field resets to 00; 11 is best, 01 and 10 unused
// RULE19 - register 25h bits 7:4 set gain in half-db steps to 6 db
// RULE20 - software writes zero into every reserved bit
// RULE21 - every register holds 00h after reset
// RULE22 - outside readout mode the pin follows the overrange condition
// RULE23 - select high clears the bit counter for a fresh word
// RULE24 - readback bit changes after a rising edge, stable at falling
module asc_config_port (
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   input  wire logic                       shift_clk,
   input  wire logic                       serial_select_n,
   input  wire logic                       serial_in_line,
   input  wire logic                       hw_reset,
   input  wire logic                       over_pos,
   input  wire logic                       over_neg,
   output      logic                       overrange_readback_pin,
   output      logic [asc_pkg::GAIN_W-1:0] gain_code,
   output      logic                       gain_disable,
   output      logic [asc_pkg::PATTERN_W-1:0] test_pattern,
   output      logic [asc_pkg::AMP_W-1:0]  amplitude_code,
   output      logic [1:0]                 perf_boost_a,
   output      logic                       perf_boost_b,
   output      logic                       standby,
   output      logic                       power_down
);

   // ************************************************************
   // serial domain
   // ************************************************************
   // reset pin acts without any clock; it is shorter than a frame
   logic                      rst_s_b;
   logic                      cnt_rst_b;
   logic [3:0]                cnt_r;
   logic [3:0]                cnt_nxt;
   logic [14:0]               shift_r;
   logic [14:0]               shift_nxt;
   logic [7:0]                regs_r   [asc_pkg::NUM_REGS];
   logic [7:0]                regs_nxt [asc_pkg::NUM_REGS];
   logic [7:0]                rb_shift_r;
   logic [7:0]                rb_shift_nxt;
   logic                      rb_out_r;
   logic                      rb_out_nxt;
   logic                      upd_tgl_r;
   logic                      upd_tgl_nxt;
   logic [7:0]                w_addr;
   logic [7:0]                w_data;
   logic [7:0]                rd_addr;
   logic                      readout;

   assign rst_s_b   = rst_b & ~hw_reset;                        // [RULE14]
   assign cnt_rst_b = rst_s_b & ~serial_select_n;               // [RULE23]
   assign w_addr    = shift_r[14:7];
   assign w_data    = {shift_r[6:0], serial_in_line};           // [RULE6]
   assign rd_addr   = {shift_r[6:0], serial_in_line};
   assign readout   = regs_r[0][asc_pkg::READBACK_BIT];

   function automatic logic [4:0] reg_slot(input logic [7:0] a);
      logic [4:0] s;
      s = 5'h10;
      if (a == asc_pkg::OFS_RESET_READBACK)    s = 5'h00;
      else if (a == asc_pkg::OFS_AMPLITUDE)    s = 5'h01;
      else if (a == asc_pkg::OFS_PERF_A)       s = 5'h02;
      else if (a == asc_pkg::OFS_GAIN_PATTERN) s = 5'h03;
      else if (a == asc_pkg::OFS_DRIVE)        s = 5'h04;
      else if (a == asc_pkg::OFS_FORMAT)       s = 5'h05;
      else if (a == asc_pkg::OFS_PATTERN_HI)   s = 5'h06;
      else if (a == asc_pkg::OFS_PATTERN_LO)   s = 5'h07;
      else if (a == asc_pkg::OFS_IFACE_RISE)   s = 5'h08;
      else if (a == asc_pkg::OFS_FALL_STANDBY) s = 5'h09;
      else if (a == asc_pkg::OFS_POWER_DOWN)   s = 5'h0a;
      else if (a == asc_pkg::OFS_PERF_B)       s = 5'h0b;
      else if (a == asc_pkg::OFS_PEDESTAL)     s = 5'h0c;
      else if (a == asc_pkg::OFS_OFFSET_LOOP)  s = 5'h0d;
      else if (a == asc_pkg::OFS_RATE_RANGE)   s = 5'h0e;
      return s;
   endfunction

   logic [4:0] w_slot;
   logic [4:0] r_slot;
   assign w_slot = reg_slot(w_addr);
   assign r_slot = reg_slot(rd_addr);

   // ************************************************************
   // falling edge: capture, commit, readback load
   // ************************************************************
   always_comb begin
      cnt_nxt      = cnt_r + 4'h1;      // wraps for back-to-back words [RULE5]
      shift_nxt    = {shift_r[13:0], serial_in_line};           // [RULE2]
      regs_nxt     = regs_r;
      upd_tgl_nxt  = upd_tgl_r;
      rb_shift_nxt = rb_shift_r;
      if (cnt_r == asc_pkg::CNT_ADDR_END) begin
         // register 0 is never returned                          [RULE12]
         if (r_slot[4] || r_slot == 5'h00) begin
            rb_shift_nxt = asc_pkg::REG_RESET;
         end else begin
            rb_shift_nxt = regs_r[r_slot[3:0]];                 // [RULE10]
         end
      end
      if (cnt_r == asc_pkg::CNT_DATA_END) begin                 // [RULE3]
         upd_tgl_nxt = ~upd_tgl_r;
         if (w_slot == 5'h00) begin
            if (w_data[asc_pkg::SW_RESET_BIT]) begin            // [RULE15]
               for (int i = 0; i < asc_pkg::NUM_REGS; i++) begin
                  regs_nxt[i] = asc_pkg::REG_RESET;
               end
            end else begin
               // only the readback bit is stored here     [RULE9] [RULE13]
               regs_nxt[0] = {7'h00, w_data[asc_pkg::READBACK_BIT]};
            end
         end else if (!readout && !w_slot[4]) begin             // [RULE9]
            regs_nxt[w_slot[3:0]] = w_data;
         end
      end
   end

   // counter cleared asynchronously: the clock stops with select high
   always_ff @(negedge shift_clk or negedge cnt_rst_b) begin
      if (!cnt_rst_b) begin
         cnt_r   <= 4'h0;                                // [RULE1] [RULE4]
         shift_r <= 15'h0000;
      end else begin
         cnt_r   <= cnt_nxt;
         shift_r <= shift_nxt;
      end
   end

   always_ff @(negedge shift_clk or negedge rst_s_b) begin
      if (!rst_s_b) begin
         for (int i = 0; i < asc_pkg::NUM_REGS; i++) begin
            regs_r[i] <= asc_pkg::REG_RESET;                    // [RULE21]
         end
         rb_shift_r <= asc_pkg::REG_RESET;
         upd_tgl_r  <= 1'b0;
      // no select gate: the counter sits at zero while deselected
      end else begin
         regs_r     <= regs_nxt;
         rb_shift_r <= rb_shift_nxt;
         upd_tgl_r  <= upd_tgl_nxt;
      end
   end

   // ************************************************************
   // rising edge: readback bit launch
   // ************************************************************
   always_comb begin
      rb_out_nxt = 1'b0;
      if (cnt_r[3]) begin
         rb_out_nxt = rb_shift_r[3'(~cnt_r[2:0])];              // [RULE24]
      end
   end

   always_ff @(posedge shift_clk or negedge cnt_rst_b) begin
      if (!cnt_rst_b) begin
         rb_out_r <= 1'b0;
      end else begin
         rb_out_r <= rb_out_nxt;
      end
   end

   // ************************************************************
   // system clock domain
   // ************************************************************
   logic       tg_s1_r;
   logic       tg_s2_r;
   logic       tg_s3_r;
   logic       rd_s1_r;
   logic       rd_s2_r;
   logic       rs_s1_r;
   logic       rs_s2_r;
   logic       ovf_r;
   logic       ovf_nxt;
   logic [7:0] sh_amp_r;
   logic [7:0] sh_perf_a_r;
   logic [7:0] sh_gain_r;
   logic [7:0] sh_stby_r;
   logic [7:0] sh_pdn_r;
   logic [7:0] sh_perf_b_r;
   logic [7:0] sh_amp_nxt;
   logic [7:0] sh_perf_a_nxt;
   logic [7:0] sh_gain_nxt;
   logic [7:0] sh_stby_nxt;
   logic [7:0] sh_pdn_nxt;
   logic [7:0] sh_perf_b_nxt;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tg_s1_r <= 1'b0;
         tg_s2_r <= 1'b0;
         tg_s3_r <= 1'b0;
         rd_s1_r <= 1'b0;
         rd_s2_r <= 1'b0;
         rs_s1_r <= 1'b1;
         rs_s2_r <= 1'b1;
      end else begin
         tg_s1_r <= upd_tgl_r;
         tg_s2_r <= tg_s1_r;
         tg_s3_r <= tg_s2_r;
         rd_s1_r <= readout;
         rd_s2_r <= rd_s1_r;
         rs_s1_r <= ~rst_s_b;
         rs_s2_r <= rs_s1_r;
      end
   end

   // register words are still when the toggle edge arrives; the next
   // commit is at least sixteen shift clocks away
   always_comb begin
      ovf_nxt       = over_pos | over_neg;                      // [RULE22]
      sh_amp_nxt    = sh_amp_r;
      sh_perf_a_nxt = sh_perf_a_r;
      sh_gain_nxt   = sh_gain_r;
      sh_stby_nxt   = sh_stby_r;
      sh_pdn_nxt    = sh_pdn_r;
      sh_perf_b_nxt = sh_perf_b_r;
      if (rs_s2_r) begin                                        // [RULE14]
         sh_amp_nxt    = asc_pkg::REG_RESET;
         sh_perf_a_nxt = asc_pkg::REG_RESET;
         sh_gain_nxt   = asc_pkg::REG_RESET;
         sh_stby_nxt   = asc_pkg::REG_RESET;
         sh_pdn_nxt    = asc_pkg::REG_RESET;
         sh_perf_b_nxt = asc_pkg::REG_RESET;
      end else if (tg_s2_r != tg_s3_r) begin
         // gate folded in here so the output is a plain flop
         sh_amp_nxt    = (regs_r[10][1:0] == asc_pkg::AMP_EN_ON) // [RULE17]
                       ? regs_r[1]                              // [RULE16]
                       : {asc_pkg::AMP_NOMINAL, 2'h0};
         sh_perf_a_nxt = regs_r[2];                             // [RULE18]
         sh_gain_nxt   = regs_r[3];                             // [RULE19]
         sh_stby_nxt   = regs_r[9];
         sh_pdn_nxt    = regs_r[10];
         sh_perf_b_nxt = regs_r[11];
      end
   end

   // pin reset clears the shadows at once, even between clk edges
   always_ff @(posedge clk or negedge rst_s_b) begin
      if (!rst_s_b) begin
         ovf_r       <= 1'b0;
         sh_amp_r    <= asc_pkg::REG_RESET;
         sh_perf_a_r <= asc_pkg::REG_RESET;
         sh_gain_r   <= asc_pkg::REG_RESET;
         sh_stby_r   <= asc_pkg::REG_RESET;
         sh_pdn_r    <= asc_pkg::REG_RESET;
         sh_perf_b_r <= asc_pkg::REG_RESET;
      end else begin
         ovf_r       <= ovf_nxt;
         sh_amp_r    <= sh_amp_nxt;
         sh_perf_a_r <= sh_perf_a_nxt;
         sh_gain_r   <= sh_gain_nxt;
         sh_stby_r   <= sh_stby_nxt;
         sh_pdn_r    <= sh_pdn_nxt;
         sh_perf_b_r <= sh_perf_b_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // pin select is a synced level; the readback bit itself must keep
   // its shift-clock launch, so it is not re-timed onto clk
   assign overrange_readback_pin = rd_s2_r ? rb_out_r : ovf_r;  // [RULE8]
   assign amplitude_code = sh_amp_r[7:2];                       // [RULE17]
   assign perf_boost_a  = sh_perf_a_r[1:0];
   assign perf_boost_b  = sh_perf_b_r[asc_pkg::PERF_B_BIT];
   assign gain_code     = sh_gain_r[7:4];
   assign gain_disable  = sh_gain_r[asc_pkg::GAIN_DIS_BIT];
   assign test_pattern  = sh_gain_r[2:0];
   assign standby       = sh_stby_r[asc_pkg::STANDBY_BIT];
   assign power_down    = sh_pdn_r[asc_pkg::PDN_BIT];

   // ************************************************************
   // checks
   // ************************************************************
   sequence s_word_end;
      cnt_r == asc_pkg::CNT_DATA_END && !serial_select_n;
   endsequence

   sequence s_addr_end;
      cnt_r == asc_pkg::CNT_ADDR_END && !serial_select_n;
   endsequence

   a_count_step: assert property (@(negedge shift_clk) // [RULE3]
      disable iff (!cnt_rst_b)
      (cnt_r != 4'h0) |-> (cnt_r == 4'($past(cnt_r) + 4'h1)))
      else $error("bit counter skipped");

   a_idle_clear: assert property (@(posedge clk) // [RULE23]
      disable iff (!rst_b)
      serial_select_n |-> (cnt_r == 4'h0))
      else $error("counter not cleared by select");

   a_word_write: assert property (@(negedge shift_clk) // [RULE5]
      disable iff (!rst_s_b)
      (s_word_end and (!readout && !w_slot[4] && w_slot != 5'h00))
      |=> (regs_r[$past(w_slot[3:0])] == $past(w_data)))
      else $error("word not committed");

   a_block_write: assert property (@(negedge shift_clk) // [RULE9]
      disable iff (!rst_s_b)
      (s_word_end and (readout && !w_slot[4] && w_slot != 5'h00))
      |=> regs_r[$past(w_slot[3:0])] == $past(regs_r[w_slot[3:0]]))
      else $error("write accepted in readout mode");

   a_soft_reset: assert property (@(negedge shift_clk) // [RULE15]
      disable iff (!rst_s_b)
      (s_word_end and (w_slot == 5'h00 && w_data[1]))
      |=> regs_r[0] == 8'h00 && regs_r[1] == 8'h00 && regs_r[3] == 8'h00)
      else $error("software reset incomplete");

   a_reg0_hidden: assert property (@(negedge shift_clk) // [RULE12]
      disable iff (!rst_s_b)
      (s_addr_end and (rd_addr == asc_pkg::OFS_RESET_READBACK))
      |=> rb_shift_r == 8'h00)
      else $error("register 0 returned on readback");

   a_rb_order: assert property (@(posedge shift_clk) // [RULE10]
      disable iff (!cnt_rst_b)
      (cnt_r == asc_pkg::CNT_DATA_BEG) |=> (rb_out_r == rb_shift_r[7]))
      else $error("readback not msb first");

   a_overrange_pin: assert property (@(posedge clk) // [RULE22]
      disable iff (!rst_s_b)
      (!rd_s2_r && (over_pos || over_neg)) ##1 !rd_s2_r
      |-> overrange_readback_pin)
      else $error("overrange not shown");

   a_amp_gate: assert property (@(posedge clk) // [RULE17]
      disable iff (!rst_b)
      (sh_pdn_r[1:0] != asc_pkg::AMP_EN_ON) |-> amplitude_code == 6'h00)
      else $error("amplitude applied while disabled");

endmodule

// ---- design/asc_pkg.sv ----
// constants of the serial configuration register bank
// assumes: one serial word = 8-bit address then 8-bit data, msb first
package asc_pkg;

   // ************************************************************
   // word layout
   // ************************************************************
   localparam int          WORD_BITS    = 16;
   localparam int          CNT_W        = 4;
   localparam logic [3:0]  CNT_ADDR_END = 4'h7;
   localparam logic [3:0]  CNT_DATA_END = 4'hf;
   localparam logic [3:0]  CNT_DATA_BEG = 4'h8;
   localparam int          NUM_REGS     = 15;
   localparam int          IDX_W        = 4;
   localparam logic [7:0]  REG_RESET    = 8'h00;

   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] OFS_RESET_READBACK = 8'h00;
   localparam logic [7:0] OFS_AMPLITUDE      = 8'h01;
   localparam logic [7:0] OFS_PERF_A         = 8'h03;
   localparam logic [7:0] OFS_GAIN_PATTERN   = 8'h25;
   localparam logic [7:0] OFS_DRIVE          = 8'h26;
   localparam logic [7:0] OFS_FORMAT         = 8'h3d;
   localparam logic [7:0] OFS_PATTERN_HI     = 8'h3f;
   localparam logic [7:0] OFS_PATTERN_LO     = 8'h40;
   localparam logic [7:0] OFS_IFACE_RISE     = 8'h41;
   localparam logic [7:0] OFS_FALL_STANDBY   = 8'h42;
   localparam logic [7:0] OFS_POWER_DOWN     = 8'h43;
   localparam logic [7:0] OFS_PERF_B         = 8'h4a;
   localparam logic [7:0] OFS_PEDESTAL       = 8'hbf;
   localparam logic [7:0] OFS_OFFSET_LOOP    = 8'hcf;
   localparam logic [7:0] OFS_RATE_RANGE     = 8'hdf;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int READBACK_BIT  = 0;
   localparam int SW_RESET_BIT  = 1;
   localparam int AMP_LSB       = 2;
   localparam int AMP_W         = 6;
   localparam int AMP_EN_LSB    = 0;
   localparam int PERF_A_LSB    = 0;
   localparam int PERF_B_BIT    = 0;
   localparam int GAIN_LSB      = 4;
   localparam int GAIN_W        = 4;
   localparam int GAIN_DIS_BIT  = 3;
   localparam int PATTERN_LSB   = 0;
   localparam int PATTERN_W     = 3;
   localparam int STANDBY_BIT   = 2;
   localparam int PDN_BIT       = 6;

   localparam logic [1:0] AMP_EN_ON    = 2'h3;
   localparam logic [5:0] AMP_NOMINAL  = 6'h00;
   localparam logic [1:0] PERF_A_BEST  = 2'h3;
   localparam logic [3:0] GAIN_MAX     = 4'hc;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int HW_RESET_MIN_NS = 10;
   localparam int SHIFT_CLK_MAX_MHZ = 20;

endpackage

// ---- testbench/asc_ctl_model.sv ----
// model of the external controller on the serial configuration port
// assumes: shift clock of 80 ns, low outside frames; idle_clocks toggles it while deselected
`timescale 1ns/100ps

module asc_ctl_model (
   output logic      shift_clk,
   output logic      serial_select_n,
   output logic      serial_in_line,
   input  wire logic overrange_readback_pin
);

   // ************************************************************
   // frame driver
   // ************************************************************
   initial begin
      shift_clk = 1'b0;
      serial_select_n = 1'b1;
      serial_in_line = 1'b1;
   end

   // bits[n-1] goes first; rd keeps the last eight captured bits
   task automatic xfer(input int n, input logic [47:0] bits,
                       output logic [7:0] rd);
      rd = 8'h00;
      serial_select_n = 1'b0;
      #40;
      for (int i = n - 1; i >= 0; i--) begin
         shift_clk = 1'b1;
         serial_in_line = bits[i];
         #40;
         shift_clk = 1'b0;
         rd = {rd[6:0], overrange_readback_pin};
         #40;
      end
      serial_select_n = 1'b1;
      // released line must not keep its last value
      serial_in_line = ~serial_in_line;
      #40;
   endtask

   // clock and data wiggle while deselected
   task automatic idle_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         shift_clk = 1'b1;
         serial_in_line = ~serial_in_line;
         #40;
         shift_clk = 1'b0;
         #40;
      end
   endtask

endmodule

// ---- testbench/tb_adc_serial_config_port.sv ----
// testbench of the serial configuration port
// assumes: design and controller model compiled before this file
`timescale 1ns/100ps

module tb_adc_serial_config_port;

   // ************************************************************
   // signals
   // ************************************************************
   logic        clk;
   logic        rst_b;
   logic        hw_reset;
   logic        over_pos;
   logic        over_neg;
   wire logic   shift_clk;
   wire logic   serial_select_n;
   wire logic   serial_in_line;
   wire logic   pin;
   wire logic [3:0] gain_code;
   wire logic   gain_disable;
   wire logic [2:0] test_pattern;
   wire logic [5:0] amplitude_code;
   wire logic [1:0] perf_boost_a;
   wire logic   perf_boost_b;
   wire logic   standby;
   wire logic   power_down;
   wire logic [18:0] outs;
   logic [7:0]  rd;
   int          n_errors;
   int          n_compared;

   assign outs = {gain_code, gain_disable, test_pattern, amplitude_code,
                  perf_boost_a, perf_boost_b, standby, power_down};

   asc_config_port dut (
      .clk                    (clk),
      .rst_b                  (rst_b),
      .shift_clk              (shift_clk),
      .serial_select_n        (serial_select_n),
      .serial_in_line         (serial_in_line),
      .hw_reset               (hw_reset),
      .over_pos               (over_pos),
      .over_neg               (over_neg),
      .overrange_readback_pin (pin),
      .gain_code              (gain_code),
      .gain_disable           (gain_disable),
      .test_pattern           (test_pattern),
      .amplitude_code         (amplitude_code),
      .perf_boost_a           (perf_boost_a),
      .perf_boost_b           (perf_boost_b),
      .standby                (standby),
      .power_down             (power_down)
   );

   asc_ctl_model ctl (
      .shift_clk              (shift_clk),
      .serial_select_n        (serial_select_n),
      .serial_in_line         (serial_in_line),
      .overrange_readback_pin (pin)
   );

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [18:0] ex(logic [7:0] r25, logic [5:0] amp,
                                      logic [1:0] pa, logic [2:0] misc);
      return {r25, amp, pa, misc};
   endfunction

   task automatic chk_vec(string what, logic [18:0] exp, logic [18:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(string what, logic exp, logic got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask

   // outputs land 2-3 clk after a commit
   task automatic settle();
      repeat (6) @(posedge clk);
      #1;
   endtask

   task automatic wr(logic [15:0] w);
      ctl.xfer(16, {32'h0, w}, rd);
      settle();
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_defaults();
      chk_vec("reset outputs", 19'h0, outs);
      chk_bit("reset pin", 1'b0, pin);
      $display("test defaults done");
   endtask

   task automatic t_multi();
      ctl.xfer(48, 48'h25c5_016c_0303, rd);
      settle();
      chk_vec("multi word", ex(8'hc5, 6'h0, 2'h3, 3'h0), outs);
      ctl.xfer(48, 48'h4343_4a01_4204, rd);
      settle();
      chk_vec("amp enabled", ex(8'hc5, 6'h1b, 2'h3, 3'h7), outs);
      $display("test multi word done");
   endtask

   task automatic t_partial();
      // trailing bits are the start of a gain write
      ctl.xfer(31, {17'h0, 16'h2601, 15'h1280}, rd);
      settle();
      chk_vec("partial", ex(8'hc5, 6'h1b, 2'h3, 3'h7), outs);
      ctl.xfer(8, 48'h25, rd);
      ctl.xfer(16, 48'h4200, rd);
      settle();
      chk_vec("fresh word", ex(8'hc5, 6'h1b, 2'h3, 3'h5), outs);
      ctl.idle_clocks(16);
      settle();
      chk_vec("deselected", ex(8'hc5, 6'h1b, 2'h3, 3'h5), outs);
      $display("test partial done");
   endtask

   task automatic t_overrange();
      @(posedge clk);
      over_pos <= 1'b1;
      settle();
      chk_bit("overrange pos", 1'b1, pin);
      @(posedge clk);
      over_pos <= 1'b0;
      over_neg <= 1'b1;
      settle();
      chk_bit("overrange neg", 1'b1, pin);
      @(posedge clk);
      over_neg <= 1'b0;
      settle();
      chk_bit("overrange clear", 1'b0, pin);
      $display("test overrange done");
   endtask

   task automatic t_readout();
      wr(16'h0001);
      @(posedge clk);
      over_pos <= 1'b1;
      ctl.xfer(16, 48'h2500, rd);
      chk_vec("read 25h", 19'(8'hc5), 19'(rd));
      wr(16'h2500);
      ctl.xfer(16, 48'h2500, rd);
      chk_vec("write blocked", 19'(8'hc5), 19'(rd));
      ctl.xfer(16, 48'h4300, rd);
      chk_vec("read 43h", 19'(8'h43), 19'(rd));
      ctl.xfer(16, 48'h0000, rd);
      chk_vec("read 00h", 19'h0, 19'(rd));
      wr(16'h0000);
      chk_bit("pin back", 1'b1, pin);
      @(posedge clk);
      over_pos <= 1'b0;
      wr(16'h2500);
      chk_vec("writes back", ex(8'h00, 6'h1b, 2'h3, 3'h5), outs);
      $display("test readout done");
   endtask

   task automatic t_swreset();
      wr(16'h25c5);
      wr(16'h0002);
      chk_vec("sw reset", 19'h0, outs);
      wr(16'h25cd);
      chk_vec("sw self clear", ex(8'hcd, 6'h0, 2'h0, 3'h0), outs);
      $display("test software reset done");
   endtask

   task automatic t_hwreset();
      wr(16'h0303);
      @(posedge clk);
      hw_reset <= 1'b1;
      @(posedge clk);
      hw_reset <= 1'b0;
      settle();
      chk_vec("hw reset", 19'h0, outs);
      $display("test hardware reset done");
   endtask

   // ************************************************************
   // run control
   // ************************************************************
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      n_errors = 0;
      n_compared = 0;
      rst_b = 1'b0;
      hw_reset = 1'b0;
      over_pos = 1'b0;
      over_neg = 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      settle();
      t_defaults();
      t_multi();
      t_partial();
      t_overrange();
      t_readout();
      t_swreset();
      t_hwreset();
      end_sim();
   end

   // whole run needs about 33 us; generous margin
   initial begin
      #500000;
      n_errors++;
      end_sim();
   end

endmodule
